/* hw/pps_params.svh */
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// ----------------------------------------------------------------
// parameter indices
// ----------------------------------------------------------------
`define PPS_IDX_MODE 16'h0080
`define PPS_IDX_SPEED 16'h00A1
`define PPS_IDX_LAGLIM 16'h00A3
`define PPS_IDX_WIN 16'h00A5
`define PPS_IDX_WINTIME 16'h00AF
`define PPS_IDX_CMD 16'h021C
`define PPS_IDX_TARGET 16'h022C
`define PPS_IDX_STATE 16'h029C
`define PPS_IDX_MODE_RB 16'h029E
`define PPS_IDX_DEMAND_ALT 16'h02B3
`define PPS_IDX_MEAS 16'h02B5
`define PPS_IDX_DEMAND 16'h02B9
`define PPS_IDX_LAGVAL 16'h02BB
`define PPS_IDX_MEAS_OBJ 16'h6063

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define PPS_MODE_PROFPOS 8'h01
`define PPS_CMD_NEWTGT 4
`define PPS_CMD_IMMED 5
`define PPS_CMD_REL 6
`define PPS_CMD_HALT 8
`define PPS_SW_REACHED 10
`define PPS_SW_ACK 12
`define PPS_SW_LAGERR 13

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PPS_RST_MODE 8'h00
`define PPS_RST_CMD 16'h0000
`define PPS_RST_WORD 32'h0000_0000
`define PPS_RST_WINTIME 16'h0000
`define PPS_CLK_PERIOD_PS 4000
`define PPS_WINTIME_UNIT_PS 1000000000
`define PPS_MS_CYCLES (`PPS_WINTIME_UNIT_PS / `PPS_CLK_PERIOD_PS)

`endif

/* hw/pps_pkg.sv */
package pps_pkg;

    typedef enum logic [1:0]
    {
        PPS_IDLE = 2'b00,
        PPS_MOVE = 2'b01,
        PPS_SETTLE = 2'b10,
        PPS_STOP = 2'b11
    } pps_state_e;

    // one target value set
    typedef struct packed
    {
        logic signed [31:0] pos;
        logic [31:0] vel;
        logic [31:0] acc;
        logic [31:0] dec;
    } pps_set_s;

    // parameter access request
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] idx;
        logic [31:0] data;
    } pps_preq_s;

    // motion feedback from trajectory and encoder logic
    typedef struct packed
    {
        logic signed [31:0] act;
        logic signed [31:0] demand;
        logic traj_done;
        logic standstill;
        logic quick_stop;
        logic fault;
    } pps_fb_s;

endpackage

/* hw/pps_ctrl.sv */
// What this block does
// R1: queued target starts on arrival, no stop
// R2: lone target: report arrival, standstill first
// R3: mode write activates mode; command word moves
// R4: new-target rise starts move; queue otherwise
// R5: immediate bit replaces current target at once
// R6: bit 6 selects absolute or relative target
// R7: halt bit stops ongoing movement
// R8: position, speed, accel, decel captured together
// R9: move ends only at standstill with cause; a mode change ends it at once
// R10: status bit 10 shows target reached
// R11: status bit 12 acknowledges accepted target
// R12: status bit 13 shows following error
// R13: reached after window held for window time
// R14: report lag in pulses; flag over limit
// R15: positions in pulses, speed in pulses/s
// R16: host queues next target via handshake bits
// R17: demand and actual positions readable
// R18: controller effort clamped to absolute limit
// R19: ack drops after host drops new-target
`timescale 1ns/1ps
`include "pps_params.svh"

module pps_ctrl
#(
    parameter int MS_CYCLES = `PPS_MS_CYCLES,
    parameter logic signed [31:0] EFFORT_LIMIT = 32'sh0000_7FFF
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire pps_pkg::pps_preq_s preq_i,
    output logic [31:0] rdata_o,
    input wire pps_pkg::pps_fb_s fb_i,
    input wire logic [31:0] accel_i,
    input wire logic [31:0] decel_i,
    input wire logic signed [31:0] effort_raw_i,
    output pps_pkg::pps_set_s set_o,
    output logic start_o,
    output logic halt_o,
    output logic stop_o,
    output logic signed [31:0] effort_o,
    output logic [15:0] state_word_o
);
    import pps_pkg::*;

    if (MS_CYCLES < 1 || MS_CYCLES > 32'h7FFF_FFFF)
    begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end
    if (EFFORT_LIMIT <= 0)
    begin : g_bad_lim
        $error("EFFORT_LIMIT must be positive");
    end

    typedef struct packed
    {
        pps_state_e state;
        logic [7:0] mode;
        logic [15:0] cmd;
        logic nt_prev;
        logic signed [31:0] target;
        logic [31:0] speed;
        logic [31:0] laglim;
        logic [31:0] win;
        logic [15:0] wintime;
        pps_set_s set;
        pps_set_s pend;
        logic pend_v;
        logic start;
        logic ack;
        logic reached;
        logic lagerr;
        logic [31:0] lagval;
        logic [31:0] ms_cnt;
        logic [15:0] win_ms;
        logic [31:0] rdata;
        logic signed [31:0] effort;
    } pps_regs_s;

    pps_regs_s s_r;
    pps_regs_s s_nxt;

    function automatic logic [31:0] pps_abs(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic active;
    logic rise;
    logic moving;
    logic halt_req;
    logic stop_req;
    logic signed [31:0] lag;
    logic in_win;
    logic win_done;
    logic ms_tick;
    logic taken;
    pps_set_s cap;
    logic [15:0] sw;

    always_comb
    begin
        active = (s_r.mode == `PPS_MODE_PROFPOS);
        rise = active && s_r.cmd[`PPS_CMD_NEWTGT] && !s_r.nt_prev;
        moving = (s_r.state == PPS_MOVE) || (s_r.state == PPS_SETTLE);
        halt_req = active && s_r.cmd[`PPS_CMD_HALT];
        stop_req = halt_req || fb_i.quick_stop || fb_i.fault;
        lag = 32'(fb_i.demand - fb_i.act);
        in_win = pps_abs(32'(s_r.set.pos - fb_i.act)) <= s_r.win;
        win_done = in_win && fb_i.standstill && (s_r.win_ms >= s_r.wintime);
        ms_tick = (s_r.ms_cnt == 32'(MS_CYCLES - 1));
        // a rise is refused only while stopping, or with the queue full and the immediate bit clear
        taken = rise && (s_r.state != PPS_STOP) && !(moving
            && !s_r.cmd[`PPS_CMD_IMMED] && s_r.pend_v);
        // the whole value set is taken in one step
        cap.pos = s_r.cmd[`PPS_CMD_REL] ? 32'(fb_i.act + s_r.target)
            : s_r.target; // R6 R8 R15
        cap.vel = s_r.speed; // R8 R15
        cap.acc = accel_i; // R8
        cap.dec = decel_i; // R8
        sw = 16'h0000;
        sw[`PPS_SW_REACHED] = s_r.reached; // R10
        sw[`PPS_SW_ACK] = s_r.ack; // R11
        sw[`PPS_SW_LAGERR] = s_r.lagerr; // R12
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.nt_prev = s_r.cmd[`PPS_CMD_NEWTGT];
        s_nxt.ms_cnt = ms_tick ? 32'h0000_0000 : 32'(s_r.ms_cnt + 1);
        s_nxt.lagval = lag; // R14
        s_nxt.lagerr = pps_abs(lag) > s_r.laglim; // R12 R14
        s_nxt.effort = effort_raw_i > EFFORT_LIMIT ? EFFORT_LIMIT
            : effort_raw_i < -EFFORT_LIMIT ? 32'(-EFFORT_LIMIT)
            : effort_raw_i; // R18

        // parameter writes take effect at once
        if (preq_i.wr)
        begin
            unique case (preq_i.idx)
                `PPS_IDX_MODE: s_nxt.mode = preq_i.data[7:0]; // R3
                `PPS_IDX_CMD: s_nxt.cmd = preq_i.data[15:0];
                `PPS_IDX_TARGET: s_nxt.target = preq_i.data;
                `PPS_IDX_SPEED: s_nxt.speed = preq_i.data;
                `PPS_IDX_LAGLIM: s_nxt.laglim = preq_i.data;
                `PPS_IDX_WIN: s_nxt.win = preq_i.data;
                `PPS_IDX_WINTIME: s_nxt.wintime = preq_i.data[15:0];
                default: s_nxt.mode = s_r.mode;
            endcase
        end

        s_nxt.rdata = 32'h0000_0000;
        if (preq_i.rd)
        begin
            unique case (preq_i.idx)
                `PPS_IDX_MODE: s_nxt.rdata = {24'h000000, s_r.mode};
                `PPS_IDX_MODE_RB: s_nxt.rdata = {24'h000000, s_r.mode};
                `PPS_IDX_CMD: s_nxt.rdata = {16'h0000, s_r.cmd};
                `PPS_IDX_TARGET: s_nxt.rdata = s_r.target;
                `PPS_IDX_SPEED: s_nxt.rdata = s_r.speed;
                `PPS_IDX_LAGLIM: s_nxt.rdata = s_r.laglim;
                `PPS_IDX_WIN: s_nxt.rdata = s_r.win;
                `PPS_IDX_WINTIME: s_nxt.rdata = {16'h0000, s_r.wintime};
                `PPS_IDX_STATE: s_nxt.rdata = {16'h0000, sw};
                `PPS_IDX_DEMAND_ALT: s_nxt.rdata = fb_i.demand; // R17
                `PPS_IDX_DEMAND: s_nxt.rdata = fb_i.demand; // R17
                `PPS_IDX_MEAS: s_nxt.rdata = fb_i.act; // R17
                `PPS_IDX_MEAS_OBJ: s_nxt.rdata = fb_i.act; // R17
                `PPS_IDX_LAGVAL: s_nxt.rdata = s_r.lagval; // R14
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // ack falls once the host drops new-target and the queue is free
        if (!s_r.cmd[`PPS_CMD_NEWTGT] && !s_r.pend_v)
        begin
            s_nxt.ack = 1'b0; // R19
        end

        // window timer runs only while settling inside the window
        if (s_r.state == PPS_SETTLE && in_win)
        begin
            if (ms_tick && s_r.win_ms != 16'hFFFF)
            begin
                s_nxt.win_ms = 16'(s_r.win_ms + 1); // R13
            end
        end
        else
        begin
            s_nxt.win_ms = 16'h0000;
        end

        unique case (s_r.state)
            PPS_IDLE:
            begin
                if (taken)
                begin
                    s_nxt.set = cap; // R4
                    s_nxt.start = 1'b1;
                    s_nxt.reached = 1'b0;
                    s_nxt.state = PPS_MOVE;
                end
            end
            PPS_MOVE:
            begin
                if (fb_i.traj_done && s_r.pend_v)
                begin
                    s_nxt.set = s_r.pend; // R1
                    s_nxt.start = 1'b1;
                    s_nxt.pend_v = 1'b0;
                end
                else if (fb_i.traj_done)
                begin
                    s_nxt.state = PPS_SETTLE;
                end
            end
            PPS_SETTLE:
            begin
                if (win_done)
                begin
                    s_nxt.reached = 1'b1; // R2 R10 R13
                    s_nxt.state = PPS_IDLE;
                    if (s_r.pend_v)
                    begin
                        s_nxt.set = s_r.pend; // R2
                        s_nxt.start = 1'b1;
                        s_nxt.pend_v = 1'b0;
                        s_nxt.state = PPS_MOVE;
                    end
                end
            end
            PPS_STOP:
            begin
                if (fb_i.standstill)
                begin
                    s_nxt.reached = in_win; // R9
                    s_nxt.state = PPS_IDLE;
                end
            end
        endcase

        if (moving && taken)
        begin
            if (s_r.cmd[`PPS_CMD_IMMED])
            begin
                s_nxt.set = cap; // R5
                s_nxt.start = 1'b1;
                s_nxt.pend_v = 1'b0;
                s_nxt.reached = 1'b0;
                s_nxt.state = PPS_MOVE;
            end
            else
            begin
                s_nxt.pend = cap; // R4 R16
                s_nxt.pend_v = 1'b1;
            end
        end
        if (taken)
        begin
            s_nxt.ack = 1'b1; // R11 R16
        end

        if (moving && stop_req)
        begin
            s_nxt.state = PPS_STOP; // R7 R9
            s_nxt.pend_v = 1'b0;
            s_nxt.start = 1'b0;
        end
        if (!active)
        begin
            s_nxt.state = PPS_IDLE; // R3
            s_nxt.pend_v = 1'b0;
            s_nxt.start = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
            s_r.mode <= `PPS_RST_MODE;
            s_r.cmd <= `PPS_RST_CMD;
            s_r.wintime <= `PPS_RST_WINTIME;
            s_r.laglim <= `PPS_RST_WORD;
            s_r.state <= PPS_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rdata_o = s_r.rdata;
    assign set_o = s_r.set;
    assign start_o = s_r.start;
    assign halt_o = halt_req; // R7
    assign stop_o = s_r.state == PPS_STOP;
    assign effort_o = s_r.effort;
    assign state_word_o = sw;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence idle_take_s;
        s_r.state == PPS_IDLE && taken && !stop_req;
    endsequence
    sequence move_begun_s;
        start_o && s_r.state == PPS_MOVE;
    endsequence

    idle_start_a: assert property (idle_take_s |=> move_begun_s) // R4
        else $error("idle rise did not start a move");
    abs_target_a: assert property (idle_take_s // R6
        ##0 !s_r.cmd[`PPS_CMD_REL] |=> set_o.pos == $past(s_r.target))
        else $error("absolute target not taken as is");
    rel_target_a: assert property (idle_take_s ##0 s_r.cmd[`PPS_CMD_REL] // R6
        |=> set_o.pos == 32'($past(fb_i.act) + $past(s_r.target)))
        else $error("relative target not added to position");
    immed_apply_a: assert property (moving && taken && active // R5
        && !stop_req && s_r.cmd[`PPS_CMD_IMMED] |=> start_o && !s_r.pend_v)
        else $error("immediate target not applied");
    chain_next_a: assert property (s_r.state == PPS_MOVE && s_r.pend_v // R1
        && fb_i.traj_done && !rise && !stop_req && active
        |=> start_o && s_r.state == PPS_MOVE)
        else $error("queued target not chained");
    halt_stop_a: assert property (active && moving && halt_req // R7
        |=> s_r.state == PPS_STOP ##0 !start_o)
        else $error("halt did not stop the move");
    stop_hold_a: assert property (s_r.state == PPS_STOP // R9
        && !fb_i.standstill && active |=> s_r.state == PPS_STOP)
        else $error("move ended before standstill");
    reached_win_a: assert property ($rose(s_r.reached) // R10 R13
        |-> $past(s_r.state == PPS_SETTLE && win_done)
        || $past(s_r.state == PPS_STOP))
        else $error("reached set without window time");
    ack_set_a: assert property (taken |=> sw[`PPS_SW_ACK]) // R11
        else $error("accepted target not acknowledged");
    ack_clear_a: assert property (s_r.ack && !s_r.cmd[`PPS_CMD_NEWTGT] // R19
        && !s_r.pend_v && !preq_i.wr |=> !s_r.ack ##1 !s_r.ack)
        else $error("ack not dropped after new-target fell");
    lag_flag_a: assert property (pps_abs(lag) > s_r.laglim // R12 R14
        |=> sw[`PPS_SW_LAGERR] && s_r.lagval == $past(lag))
        else $error("following error not flagged");
    effort_clamp_a: assert property (effort_o <= EFFORT_LIMIT // R18
        && effort_o >= -EFFORT_LIMIT)
        else $error("effort beyond limit");
    mode_write_a: assert property (preq_i.wr // R3
        && preq_i.idx == `PPS_IDX_MODE
        |=> s_r.mode == $past(preq_i.data[7:0]))
        else $error("mode write not active at once");

endmodule

/* verification/pps_host.sv */
`timescale 1ns/1ps
`include "pps_params.svh"

module pps_host
(
    input wire logic core_clk_i,
    input wire logic [31:0] rdata_i,
    output pps_pkg::pps_preq_s preq_o
);
    import pps_pkg::*;

    initial preq_o = '0;

    // ------------------------------------------------------------
    // parameter access
    // ------------------------------------------------------------
    // released lines show the inverse so stale values never match
    task automatic access(input logic w, input logic [15:0] idx,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk_i) #1;
        preq_o = '{wr: w, rd: ~w, idx: idx, data: d};
        @(posedge core_clk_i) #1;
        q = rdata_i;
        preq_o = '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~d};
    endtask

    // ------------------------------------------------------------
    // set-point handshake
    // ------------------------------------------------------------
    // raise new-target, poll for acknowledge, then drop new-target
    task automatic raise(input logic [15:0] cmd, output logic ok);
        logic [31:0] q;
        int n;
        access(1'b1, `PPS_IDX_CMD, {16'h0000, cmd | 16'h0010}, q);
        n = 0;
        do
        begin
            access(1'b0, `PPS_IDX_STATE, 32'h0000_0000, q);
            n++;
        end
        while (q[`PPS_SW_ACK] !== 1'b1 && n < 50);
        ok = q[`PPS_SW_ACK];
        access(1'b1, `PPS_IDX_CMD, {16'h0000, cmd & 16'hFFEF}, q);
    endtask
endmodule

/* verification/pps_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "pps_params.svh"

module pps_ctrl_tb_top;
    import pps_pkg::*;

    localparam int MS = 4;
    localparam logic signed [31:0] LIM = 32'sh0000_7FFF;
    logic core_clk_i;
    logic rst_n_i;
    pps_preq_s preq;
    logic [31:0] rdata;
    pps_fb_s fb;
    logic [31:0] acc_pin;
    logic [31:0] dec_pin;
    logic signed [31:0] eff_raw;
    pps_set_s set;
    logic start;
    logic halt;
    logic stop;
    logic signed [31:0] eff;
    logic signed [31:0] v;
    logic [15:0] sw;
    logic [31:0] spd;
    int miscompares = 0;
    int tests_run = 0;
    int n_start = 0;
    int cycles = 0;
    int ta, tb, tc, td;
    pps_set_s sq[$];
    // watched levels: ack, reached, start, stop
    logic [3:0] watch;
    localparam int W_ACK = 0;
    localparam int W_REACH = 1;
    localparam int W_START = 2;
    localparam int W_STOP = 3;

    assign watch = {stop, start, sw[`PPS_SW_REACHED], sw[`PPS_SW_ACK]};

    pps_ctrl #(.MS_CYCLES(MS), .EFFORT_LIMIT(LIM)) pps_ctrl_i
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .preq_i(preq),
        .rdata_o(rdata),
        .fb_i(fb),
        .accel_i(acc_pin),
        .decel_i(dec_pin),
        .effort_raw_i(eff_raw),
        .set_o(set),
        .start_o(start),
        .halt_o(halt),
        .stop_o(stop),
        .effort_o(eff),
        .state_word_o(sw)
    );

    pps_host pps_host_i
    (
        .core_clk_i(core_clk_i),
        .rdata_i(rdata),
        .preq_o(preq)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_set(input pps_set_s e, input pps_set_s g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error target set expected %h seen %h", e, g);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // every load of the active set that raises start is compared with the model queue
    always @(negedge core_clk_i)
    begin
        if (start === 1'b1)
        begin
            n_start++;
            chk_set(sq.size() > 0 ? sq.pop_front() : '0, set);
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic put(input logic [15:0] i, input logic [31:0] d);
        logic [31:0] q;
        pps_host_i.access(1'b1, i, d, q);
    endtask

    task automatic rdchk(input string nm, input logic [15:0] i,
        input logic [31:0] e);
        logic [31:0] q;
        pps_host_i.access(1'b0, i, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    task automatic wait_sig(input string nm, input int k, input logic e,
        input int lim);
        int n;
        n = 0;
        while (watch[k] !== e && n < lim)
        begin
            cyc(1);
            n++;
        end
        chk(nm, e, watch[k]);
    endtask

    task automatic go(input logic [15:0] cmd, input int t, input int e);
        logic ok;
        put(`PPS_IDX_TARGET, t);
        sq.push_back('{pos: e, vel: spd, acc: acc_pin, dec: dec_pin});
        pps_host_i.raise(cmd, ok);
        chk("acknowledge", 1, ok);
    endtask

    task automatic place(input int p);
        fb.act = p;
        fb.demand = p;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(75692));
        rst_n_i = 1'b0;
        fb = '0;
        acc_pin = $urandom;
        dec_pin = $urandom;
        eff_raw = '0;
        repeat (20) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        chk("state_word", 0, sw);
        rdchk("mode", `PPS_IDX_MODE_RB, 0);
        put(`PPS_IDX_MODE, 1);
        rdchk("mode", `PPS_IDX_MODE_RB, 1);
        rdchk("mode", `PPS_IDX_MODE, 1);
        spd = $urandom;
        put(`PPS_IDX_SPEED, spd);
        put(`PPS_IDX_LAGLIM, 20);
        put(`PPS_IDX_WIN, 5);
        put(`PPS_IDX_WINTIME, 2);
        rdchk("speed", `PPS_IDX_SPEED, spd);
        rdchk("lag limit", `PPS_IDX_LAGLIM, 20);
        rdchk("window", `PPS_IDX_WIN, 5);
        rdchk("window time", `PPS_IDX_WINTIME, 2);
        rdchk("unmapped", 16'h0123, 0);
        place($urandom_range(900, 100));
        put(`PPS_IDX_MEAS, 0);
        rdchk("measured", `PPS_IDX_MEAS, fb.act);
        rdchk("demand", `PPS_IDX_DEMAND, fb.demand);
        rdchk("demand alt", `PPS_IDX_DEMAND_ALT, fb.demand);
        rdchk("measured obj", `PPS_IDX_MEAS_OBJ, fb.act);
        $display("test registers done");
        ta = $urandom;
        tb = $urandom_range(5000);
        tc = $urandom_range(5000);
        td = $urandom;
        go(16'h0000, ta, ta);
        chk("starts", 1, n_start);
        chk("reached", 0, sw[`PPS_SW_REACHED]);
        wait_sig("ack", W_ACK, 1'b0, 40);
        go(16'h0060, tb, tb + fb.act);
        chk("starts", 2, n_start);
        go(16'h0000, tc, tc);
        cyc(10);
        chk("starts", 2, n_start);
        place(set.pos);
        fb.traj_done = 1'b1;
        fb.standstill = 1'b1;
        wait_sig("queued load", W_START, 1'b1, 200);
        cyc(1);
        fb.traj_done = 1'b0;
        chk("starts", 3, n_start);
        wait_sig("ack", W_ACK, 1'b0, 40);
        chk("reached", 0, sw[`PPS_SW_REACHED]);
        place(tc + 3);
        fb.traj_done = 1'b1;
        cyc(3);
        chk("reached", 0, sw[`PPS_SW_REACHED]);
        wait_sig("reached", W_REACH, 1'b1, 60);
        fb.demand = fb.act + 30;
        cyc(3);
        chk("lag flag", 1, sw[`PPS_SW_LAGERR]);
        rdchk("lag value", `PPS_IDX_LAGVAL, 30);
        fb.demand = fb.act + 10;
        cyc(3);
        chk("lag flag", 0, sw[`PPS_SW_LAGERR]);
        $display("test moves done");
        fb.traj_done = 1'b0;
        fb.standstill = 1'b0;
        go(16'h0000, td, td);
        chk("starts", 4, n_start);
        put(`PPS_IDX_CMD, 16'h0100);
        chk("halt", 1, halt);
        wait_sig("stop", W_STOP, 1'b1, 10);
        fb.standstill = 1'b1;
        wait_sig("stop", W_STOP, 1'b0, 20);
        put(`PPS_IDX_CMD, 16'h0000);
        chk("halt", 0, halt);
        $display("test halt done");
        // quick stop first, then a fault, each during a move
        for (int k = 0; k < 2; k++)
        begin
            fb.standstill = 1'b0;
            go(16'h0000, tc, tc);
            chk("starts", 5 + k, n_start);
            fb.quick_stop = (k == 0);
            fb.fault = (k == 1);
            wait_sig("stop", W_STOP, 1'b1, 10);
            fb.quick_stop = 1'b0;
            fb.fault = 1'b0;
            fb.standstill = 1'b1;
            wait_sig("stop", W_STOP, 1'b0, 20);
        end
        $display("test stop causes done");
        for (int i = 0; i < 24; i++)
        begin
            eff_raw = (i % 2) ? $urandom : $urandom_range(65535) - 32768;
            v = eff_raw > LIM ? LIM : (eff_raw < -LIM ? -LIM : eff_raw);
            cyc(1);
            chk("effort", v, eff);
        end
        chk("state_word spare", 0, sw & 16'hCBFF);
        $display("test effort done");
        finish_test();
    end
endmodule
